// >>> pmu_alarm_pkg.sv
// Shared constants and the sticky flag bank for the alarm and mode-pin block
`timescale 1ns/100ps
package pmu_alarm_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int          NUM_CH        = 4;
  localparam int          ADDR_W        = 8;
  localparam int          TEMP_W        = 8;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0]  ADDR_SYSCTRL  = 8'h00;
  localparam logic [7:0]  ADDR_THRESH   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_PMU0     = 8'h10;
  localparam logic [7:0]  ADDR_PMU_LAST = 8'h1C;
  // ****************************************
  // System control fields and reset values
  // ****************************************
  localparam int          CTL_CG_EN     = 0;
  localparam int          CTL_CG_LATCH  = 1;
  localparam int          CTL_GUARD_EN  = 2;
  localparam int          CTL_CLAMP_EN  = 3;
  localparam int          CTL_CMP_KEEP  = 4;
  localparam int          CTL_GND_LSB   = 8;
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam logic [15:0] PMU_RESET     = 16'h0000;
  localparam int          PMU_CLEAR_BIT = 6;
  localparam logic [7:0]  TEMP_DEFAULT  = 8'h82;
  // ****************************************
  // Status layout: temp pair, then four bits per channel
  // ****************************************
  localparam int          ST_TEMP_STICKY = 0;
  localparam int          ST_TEMP_LIVE   = 1;
  localparam int          ST_CH_LSB      = 2;
  localparam int          ST_W           = 18;
  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : pmu_alarm_pkg

module sticky_flags #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clear,
  output logic      [W-1:0] flags
);
  logic [W-1:0] next_flags;

  // Set beats clear so an event in the clear cycle is kept
  always_comb begin
    next_flags = (flags & {W{~clear}}) | set;
  end

  // ****************************************
  // Flag storage
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : sticky_flags

// >>> pmu_alarm.sv
// Alarm pins, mode pins and register slave of the quad measurement unit
// Contract
// - Low reset level returns every state element to its power-on value.
// - Over-temperature output pulls low and stays low once threshold (130C default) exceeded.
// - Status holds a sticky and a live over-temperature flag.
// - Writing bit 6 in any channel register releases the temperature latch.
// - Guard/clamp output stays disabled after reset until software enables it.
// - System control enables guard/clamp output and picks latched or live behaviour.
// - Only software-selected sources, guard, clamp or both, drive that output.
// - Each channel reports latched and live flags per alarm source.
// - Interface select low means SPI, high means LVDS; board straps it.
// - In LVDS mode comparator pins default to serial interface pins.
// - Shared low sense by default; each channel may use its own guard pin.
// - Guard pin is guard input at power-on; as sense, guard takes high sense.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module pmu_alarm
  import pmu_alarm_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [TEMP_W-1:0] temp_code,
  input  wire logic [NUM_CH-1:0] guard_fault,
  input  wire logic [NUM_CH-1:0] clamp_fault,
  input  wire logic              serial_mode_select,
  input  wire logic [NUM_CH-1:0] comparator_high_raw,
  input  wire logic [NUM_CH-1:0] comparator_low_raw,
  output logic                   overtemp_alarm_out_o,
  output logic                   overtemp_alarm_out_oe,
  output logic                   guard_clamp_alarm_out_o,
  output logic                   guard_clamp_alarm_out_oe,
  output logic                   lvds_mode,
  output logic                   comparator_pins_serial,
  output logic [NUM_CH-1:0]      comparator_high_out,
  output logic [NUM_CH-1:0]      comparator_low_out,
  output logic [NUM_CH-1:0]      ground_sense_sel,
  output logic [NUM_CH-1:0]      guard_from_high_sense
);
  // ****************************************
  // Decoding helpers
  // ****************************************
  // Any of the four channel registers
  function automatic logic is_pmu_addr(input logic [ADDR_W-1:0] a);
    return (a >= ADDR_PMU0) && (a <= ADDR_PMU_LAST) && (a[1:0] == 2'h0);
  endfunction : is_pmu_addr

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SW = 4 * NUM_CH + 1;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  logic [NUM_CH-1:0] guard_live, clamp_live;
  logic [NUM_CH-1:0] cmp_high_s, cmp_low_s;

  // Two flops on every pin input; only stage two is read
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {serial_mode_select, comparator_low_raw, comparator_high_raw,
                   clamp_fault, guard_fault};
      pin_sync <= pin_meta;
    end
  end

  assign guard_live = pin_sync[NUM_CH-1:0];
  assign clamp_live = pin_sync[2*NUM_CH-1:NUM_CH];
  assign cmp_high_s = pin_sync[3*NUM_CH-1:2*NUM_CH];
  assign cmp_low_s  = pin_sync[4*NUM_CH-1:3*NUM_CH];

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic              aw_held, next_aw_held;
  logic              w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;
  logic              have_aw, have_w, do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [15:0]       sysctrl, next_sysctrl;
  logic [TEMP_W-1:0] thresh, next_thresh;
  logic [15:0]       pmu_reg [NUM_CH];
  logic [15:0]       next_pmu_reg [NUM_CH];
  logic              clear_hit;
  logic [ST_W-1:0]   status_vec;

  // Handshake readies, held off while a response is pending
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  // Address and data may arrive in either order
  assign have_aw  = aw_held || (awvalid && awready);
  assign have_w   = w_held || (wvalid && wready);
  assign do_write = have_aw && have_w && !bvalid;
  assign wr_addr  = aw_held ? aw_addr : awaddr;
  assign wr_data  = w_held ? w_data : wdata;
  assign wr_strb  = w_held ? w_strb : wstrb;

  // Clear strobe: low byte written with bit 6 set in a channel register
  assign clear_hit = do_write && is_pmu_addr(wr_addr) && wr_strb[0]
                     && wr_data[PMU_CLEAR_BIT];

  // Write side and register file next state
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bresp   = bresp;
    next_bvalid  = bvalid && !bready;
    next_sysctrl = sysctrl;
    next_thresh  = thresh;
    for (int c = 0; c < NUM_CH; c++) begin
      next_pmu_reg[c] = pmu_reg[c];
    end
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (wr_addr == ADDR_SYSCTRL) begin
        next_sysctrl = merge16(sysctrl, wr_data, wr_strb);
      end else if (wr_addr == ADDR_THRESH) begin
        if (wr_strb[0]) begin
          next_thresh = wr_data[TEMP_W-1:0];
        end
      end else if (is_pmu_addr(wr_addr)) begin
        // Clear bit is a strobe and is never stored
        for (int c = 0; c < NUM_CH; c++) begin
          if (wr_addr[4:2] == 3'(c + 4)) begin
            next_pmu_reg[c] = merge16(pmu_reg[c], wr_data, wr_strb)
                              & ~(16'h0001 << PMU_CLEAR_BIT);
          end
        end
      end else if (wr_addr != ADDR_STATUS) begin
        next_bresp = RESP_SLVERR;
      end
    end
  end

  // Read side; data is captured when the address is taken
  always_comb begin
    next_rvalid = rvalid && !rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (araddr == ADDR_SYSCTRL) begin
        next_rdata = {16'h0000, sysctrl};
      end else if (araddr == ADDR_THRESH) begin
        next_rdata = {24'h00_0000, thresh};
      end else if (araddr == ADDR_STATUS) begin
        next_rdata = {{(32-ST_W){1'b0}}, status_vec};
      end else if (is_pmu_addr(araddr)) begin
        next_rdata = {16'h0000, pmu_reg[araddr[3:2]]};
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  // Every bus and register flop returns to its power-on value
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bresp   <= RESP_OKAY;
      bvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      sysctrl <= CTL_RESET;
      thresh  <= TEMP_DEFAULT;
      for (int c = 0; c < NUM_CH; c++) begin
        pmu_reg[c] <= PMU_RESET;
      end
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bresp   <= next_bresp;
      bvalid  <= next_bvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      rvalid  <= next_rvalid;
      sysctrl <= next_sysctrl;
      thresh  <= next_thresh;
      for (int c = 0; c < NUM_CH; c++) begin
        pmu_reg[c] <= next_pmu_reg[c];
      end
    end
  end

  // ****************************************
  // Alarm flags
  // ****************************************
  logic              over_live;
  logic              temp_sticky;
  logic [NUM_CH-1:0] guard_sticky;
  logic [NUM_CH-1:0] clamp_sticky;
  logic              cg_enable, cg_latch, cg_guard_en, cg_clamp_en;
  logic              cg_sel_live, cg_sel_sticky;
  logic              cg_drive, next_cg_drive;
  logic [NUM_CH-1:0] next_cmp_high, next_cmp_low;
  logic              next_pins_serial;

  // Strictly above the threshold counts as exceeding it
  assign over_live = temp_code > thresh;

  sticky_flags #(
    .W (1 + 2 * NUM_CH)
  ) i_sticky_flags (
    .mclk   (mclk),
    .resetn (resetn),
    .set    ({clamp_live, guard_live, over_live}),
    .clear  (clear_hit),
    .flags  ({clamp_sticky, guard_sticky, temp_sticky})
  );

  // Status word packs one latched and one live flag per source
  always_comb begin
    status_vec = '0;
    status_vec[ST_TEMP_STICKY] = temp_sticky;
    status_vec[ST_TEMP_LIVE]   = over_live;
    for (int c = 0; c < NUM_CH; c++) begin
      status_vec[ST_CH_LSB + 4*c]     = guard_sticky[c];
      status_vec[ST_CH_LSB + 4*c + 1] = guard_live[c];
      status_vec[ST_CH_LSB + 4*c + 2] = clamp_sticky[c];
      status_vec[ST_CH_LSB + 4*c + 3] = clamp_live[c];
    end
  end

  assign cg_enable   = sysctrl[CTL_CG_EN];
  assign cg_latch    = sysctrl[CTL_CG_LATCH];
  assign cg_guard_en = sysctrl[CTL_GUARD_EN];
  assign cg_clamp_en = sysctrl[CTL_CLAMP_EN];

  // Only the selected sources reach the shared pin
  assign cg_sel_live   = (cg_guard_en && |guard_live)
                         || (cg_clamp_en && |clamp_live);
  assign cg_sel_sticky = (cg_guard_en && |guard_sticky)
                         || (cg_clamp_en && |clamp_sticky);

  // Pin drive and comparator pin routing
  always_comb begin
    next_cg_drive    = cg_enable && (cg_latch ? cg_sel_sticky : cg_sel_live);
    next_pins_serial = lvds_mode && !sysctrl[CTL_CMP_KEEP];
    next_cmp_high    = next_pins_serial ? '0 : cmp_high_s;
    next_cmp_low     = next_pins_serial ? '0 : cmp_low_s;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cg_drive               <= 1'b0;
      comparator_pins_serial <= 1'b0;
      comparator_high_out    <= '0;
      comparator_low_out     <= '0;
    end else begin
      cg_drive               <= next_cg_drive;
      comparator_pins_serial <= next_pins_serial;
      comparator_high_out    <= next_cmp_high;
      comparator_low_out     <= next_cmp_low;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // Open drain: data fixed low, the enable does the signalling
  assign overtemp_alarm_out_o     = 1'b0;
  assign overtemp_alarm_out_oe    = temp_sticky;
  assign guard_clamp_alarm_out_o  = 1'b0;
  assign guard_clamp_alarm_out_oe = cg_drive;
  // Strap is synchronised; board must hold it steady
  assign lvds_mode                = pin_sync[SW-1];
  assign ground_sense_sel         = sysctrl[CTL_GND_LSB +: NUM_CH];
  assign guard_from_high_sense    = sysctrl[CTL_GND_LSB +: NUM_CH];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_temp_sets_pin: assert property (over_live |=> overtemp_alarm_out_oe)
    else $error("temp alarm pin not pulled after over temperature");
  a_temp_holds: assert property (overtemp_alarm_out_oe && !clear_hit |=> overtemp_alarm_out_oe)
    else $error("temp alarm released without clear");
  a_temp_clear: assert property (clear_hit && !over_live |=> !overtemp_alarm_out_oe)
    else $error("temp alarm not released by clear");
  a_status_sticky: assert property (over_live |=> status_vec[ST_TEMP_STICKY])
    else $error("sticky temp flag missing");
  a_cg_disabled: assert property (!cg_enable |=> !guard_clamp_alarm_out_oe)
    else $error("guard clamp pin driven while disabled");
  a_cg_follow: assert property (cg_enable && !cg_latch && cg_sel_live |=> guard_clamp_alarm_out_oe)
    else $error("guard clamp pin missed live alarm");
  a_cg_latched: assert property (cg_enable && cg_latch && cg_sel_sticky && !do_write
                                 |=> guard_clamp_alarm_out_oe ##1 guard_clamp_alarm_out_oe)
    else $error("latched guard clamp alarm dropped");
  a_cg_no_source: assert property (!cg_guard_en && !cg_clamp_en |=> !guard_clamp_alarm_out_oe)
    else $error("unselected source drove guard clamp pin");
  a_chan_flags: assert property ($rose(guard_live[0]) |=> guard_sticky[0]
                                 ##1 (guard_sticky[0] || $past(clear_hit)))
    else $error("guard fault not latched");
  a_cmp_serial: assert property (lvds_mode && !sysctrl[CTL_CMP_KEEP]
                                 |=> comparator_pins_serial && comparator_high_out == '0)
    else $error("comparator pins not handed to serial");
  a_gnd_route: assert property (do_write && wr_addr == ADDR_SYSCTRL && wr_strb[1]
    |=> guard_from_high_sense == $past(wr_data[CTL_GND_LSB +: NUM_CH]))
    else $error("guard input routing disagrees with sense select");
  a_cg_pulls: assert property (guard_clamp_alarm_out_oe |-> $past(cg_enable))
    else $error("guard clamp pin pulled while disabled");
  a_mode_follow: assert property (lvds_mode == $past(pin_meta[SW-1]))
    else $error("mode not taken from strap");

  c_temp_clear: cover property (overtemp_alarm_out_oe ##1 clear_hit ##1 !overtemp_alarm_out_oe);
  c_cg_latched: cover property (cg_enable && cg_latch && guard_clamp_alarm_out_oe);
  c_cg_live: cover property (cg_enable && !cg_latch && guard_clamp_alarm_out_oe);
  c_lvds: cover property (comparator_pins_serial);
endmodule : pmu_alarm

// >>> alarm_host_model.sv
// Board model: pulled-up open-drain alarm wires and the mode strap
`timescale 1ns/100ps
module alarm_host_model (
  input  wire logic ot_o,
  input  wire logic ot_oe,
  input  wire logic cg_o,
  input  wire logic cg_oe,
  input  wire logic lvds_strap,
  output logic      ot_wire,
  output logic      cg_wire,
  output logic      mode_pin
);
  // ****
  // Wire levels
  // ****
  // Pull-ups win whenever the device lets go, so a stale low never lingers
  assign ot_wire  = ot_oe ? ot_o : 1'h1;
  assign cg_wire  = cg_oe ? cg_o : 1'h1;
  // Strap is fixed by the board, never toggled inside a frame
  assign mode_pin = lvds_strap;
endmodule : alarm_host_model

// >>> pmu_alarm_tb.sv
// Self-checking bench for the alarm and mode-pin block
`timescale 1ns/100ps
module pmu_alarm_tb;
  import pmu_alarm_pkg::*;
  // ****
  // Signals
  // ****
  logic              mclk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, strap, mode_pin, lvds_mode, pins_ser;
  logic              ot_o, ot_oe, cg_o, cg_oe, ot_wire, cg_wire;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, seed;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [TEMP_W-1:0] temp_code, t, thr;
  logic [NUM_CH-1:0] gflt, cflt, cmp_h, cmp_l, cmp_h_out, cmp_l_out, gsel, gfeed;
  logic [33:0]       exp_q[$];
  int                failures, comparisons;

  pmu_alarm i_pmu_alarm (.mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .temp_code(temp_code), .guard_fault(gflt), .clamp_fault(cflt),
    .serial_mode_select(mode_pin), .comparator_high_raw(cmp_h), .comparator_low_raw(cmp_l),
    .overtemp_alarm_out_o(ot_o), .overtemp_alarm_out_oe(ot_oe),
    .guard_clamp_alarm_out_o(cg_o), .guard_clamp_alarm_out_oe(cg_oe),
    .lvds_mode(lvds_mode), .comparator_pins_serial(pins_ser),
    .comparator_high_out(cmp_h_out), .comparator_low_out(cmp_l_out),
    .ground_sense_sel(gsel), .guard_from_high_sense(gfeed));

  alarm_host_model i_alarm_host_model (.ot_o(ot_o), .ot_oe(ot_oe), .cg_o(cg_o),
    .cg_oe(cg_oe), .lvds_strap(strap), .ot_wire(ot_wire), .cg_wire(cg_wire),
    .mode_pin(mode_pin));

  // 25 MHz clock
  always #20 mclk = ~mclk;

  // ****
  // Checking
  // ****
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic tmo;
    failures++;
    $display("[ERR] %0t bus answer missing", $time);
    tally_and_finish();
  endtask : tmo

  // Watcher: each bus answer takes the oldest note off the queue
  always @(negedge mclk) begin
    if (bvalid && bready) begin
      if (exp_q.size() == 0) tmo();
      else chk({bresp, 32'h0}, exp_q.pop_front());
    end
    if (rvalid && rready) begin
      if (exp_q.size() == 0) tmo();
      else chk({rresp, rdata}, exp_q.pop_front());
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // ****
  // Bus master; handshakes sampled at the settled falling edge
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_go, w_go, b_go;
    int   n;
    exp_q.push_back({er, 32'h0});
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    n = 0;
    do begin
      @(negedge mclk);
      aw_go = awvalid & awready;
      w_go  = wvalid & wready;
      b_go  = bvalid & bready;
      @(posedge mclk);
      if (aw_go) awvalid <= 1'h0;
      if (w_go) wvalid <= 1'h0;
      n++;
      if (n > 50) tmo();
    end while (!b_go);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ar_go, r_go;
    int   n;
    exp_q.push_back({er, d});
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    n = 0;
    do begin
      @(negedge mclk);
      ar_go = arvalid & arready;
      r_go  = rvalid & rready;
      @(posedge mclk);
      if (ar_go) arvalid <= 1'h0;
      n++;
      if (n > 50) tmo();
    end while (!r_go);
    rready <= 1'h0;
  endtask : rd

  // Long enough for the two-flop sync plus the flag and pin stages
  task automatic settle;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task automatic do_reset;
    resetn <= 1'h0;
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
  endtask : do_reset

  // ****
  // Scenarios
  // ****
  initial begin
    {mclk, awvalid, wvalid, bready, arvalid, rready, strap} = '0;
    {awaddr, araddr, wdata, wstrb, gflt, cflt, cmp_h, cmp_l} = '0;
    temp_code = 8'h19;
    resetn = 1'h0;
    seed = 32'hA802;
    repeat (3) @(posedge mclk);
    resetn <= 1'h1;
    rd(ADDR_SYSCTRL, {16'h0, CTL_RESET}, RESP_OKAY);
    rd(ADDR_THRESH, {24'h0, TEMP_DEFAULT}, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hFFFF, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFFFF, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    // Over-temperature: latch holds after the condition goes
    temp_code <= 8'h83;
    settle();
    chk({33'h0, ot_wire}, 34'h0);
    rd(ADDR_STATUS, 32'h3, RESP_OKAY);
    temp_code <= 8'h82;
    settle();
    chk({33'h0, ot_wire}, 34'h0);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_PMU0, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ADDR_PMU0, 32'h0000_FFBF, RESP_OKAY);
    settle();
    chk({33'h0, ot_wire}, 34'h1);
    // Random threshold and temperatures, cleared through every channel register
    seed = xs(seed);
    thr  = seed[15:8];
    wr(ADDR_THRESH, {24'h0, thr}, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      t    = seed[7:0];
      @(posedge mclk);
      temp_code <= t;
      settle();
      wr(ADDR_PMU0 + 8'(4 * (i % 4)), 32'h40, RESP_OKAY);
      settle();
      chk({33'h0, ot_wire}, {33'h0, !(t > thr)});
      rd(ADDR_STATUS, (t > thr) ? 32'h3 : 32'h0, RESP_OKAY);
    end
    @(posedge mclk);
    temp_code <= 8'h0;
    settle();
    wr(ADDR_PMU_LAST, 32'h40, RESP_OKAY);
    // Guard/clamp pin in live mode, every source selection
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_SYSCTRL, 32'h1 | (32'(s) << CTL_GUARD_EN), RESP_OKAY);
      @(posedge mclk);
      gflt <= 4'h1;
      settle();
      chk({33'h0, cg_wire}, {33'h0, !s[0]});
      @(posedge mclk);
      gflt <= 4'h0;
      cflt <= 4'h4;
      settle();
      chk({33'h0, cg_wire}, {33'h0, !s[1]});
      @(posedge mclk);
      cflt <= 4'h0;
    end
    settle();
    rd(ADDR_STATUS, 32'h1004, RESP_OKAY);
    // Sources on, pin off: flags record but the wire stays released
    wr(ADDR_SYSCTRL, 32'hC, RESP_OKAY);
    gflt <= 4'h1;
    settle();
    chk({33'h0, cg_wire}, 34'h1);
    rd(ADDR_STATUS, 32'h100C, RESP_OKAY);
    gflt <= 4'h0;
    // Fault must leave the synchroniser first, or the set would beat the clear
    settle();
    wr(ADDR_PMU0, 32'h40, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    // Latched mode holds until a clear
    wr(ADDR_SYSCTRL, 32'h7, RESP_OKAY);
    gflt <= 4'h2;
    settle();
    @(posedge mclk);
    gflt <= 4'h0;
    settle();
    chk({33'h0, cg_wire}, 34'h0);
    wr(ADDR_PMU0 + 8'h8, 32'h40, RESP_OKAY);
    settle();
    chk({33'h0, cg_wire}, 34'h1);
    // Ground sense routing and comparator pins in both serial modes
    wr(ADDR_SYSCTRL, 32'h0A00, RESP_OKAY);
    cmp_h <= 4'h5;
    cmp_l <= 4'h3;
    settle();
    chk({26'h0, gsel, gfeed}, 34'hAA);
    chk({24'h0, lvds_mode, pins_ser, cmp_h_out, cmp_l_out}, 34'h053);
    @(posedge mclk);
    strap <= 1'h1;
    settle();
    chk({24'h0, lvds_mode, pins_ser, cmp_h_out, cmp_l_out}, 34'h300);
    wr(ADDR_SYSCTRL, 32'h10, RESP_OKAY);
    settle();
    chk({26'h0, gsel, gfeed}, 34'h0);
    chk({24'h0, lvds_mode, pins_ser, cmp_h_out, cmp_l_out}, 34'h253);
    // Reset in mid-run returns registers and routing to power-on values
    @(posedge mclk);
    do_reset();
    rd(ADDR_SYSCTRL, 32'h0, RESP_OKAY);
    settle();
    chk({26'h0, gsel, gfeed}, 34'h0);
    tally_and_finish();
  end
endmodule : pmu_alarm_tb
